// *** hw/vthp_top.sv ***
// Summary of operation
// - With separate strobes an access counts only while read or write strobe is low, and select picks the register.
// - Select 0 with write strobe active and read strobe idle stores the bus byte into the pointed data register.
// - Select 1 with write strobe active and read strobe idle stores the bus byte into the pointer register.
// - The bus byte latched during the write strobe is stored into the selected register when the processor releases the strobe.
// - The selected register drives the bus while the read strobe is active, and the bus is released otherwise.
// - With the data strobe data moves only while the strobe is low, in the direction given by read/write.
// - The eight-bit processor bus is driven only during reads and is an input otherwise.
// - The processor loads the pointer first, and the next data access reaches the pointed register.
// - Pointer low nibble 6,8,9,a,b,c,d,e picks chip reset, screen top, cursor lo/hi, fill end, attribute, character, mode.
// - Status bit 7 sets when a transfer or fill completes and clears on any character access, except in a cycle where a completion also arrives.
`include "vthp_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module vthp_top #(
    parameter vthp_pkg::vthp_variant_t VARIANT = vthp_pkg::VTHP_SEPARATE_STROBES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic host_rd_n,
    input wire logic host_wr_n,
    input wire logic host_rw,
    input wire logic host_data_strobe_n,
    input wire logic host_sel,
    input wire logic [7:0] host_bus_i,
    output logic [7:0] host_bus_o,
    output logic host_bus_oe,
    input wire logic xfer_done,
    input wire logic char_load,
    input wire logic [7:0] char_load_data,
    output logic [7:0] screen_top_address,
    output logic [7:0] cursor_low,
    output logic [7:0] cursor_high,
    output logic [7:0] fill_end_address,
    output logic [7:0] attribute_value,
    output logic [7:0] mode_value,
    output logic [7:0] char_value,
    output logic fill_armed,
    output logic xfer_start,
    output logic chip_reset_pulse
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [4:0] ctl_s;
    logic [7:0] bus_s;
    logic rd_n_s;
    logic wr_n_s;
    logic rw_s;
    logic ds_n_s;
    logic sel_s;

    vthp_sync #(.W(5), .RST(5'h0f)) u_sync_ctl (
        .clk(clk),
        .rstn(rstn),
        .d({host_sel, host_rw, host_data_strobe_n, host_wr_n, host_rd_n}),
        .q(ctl_s)
    );

    vthp_sync #(.W(8), .RST(8'h00)) u_sync_bus (
        .clk(clk),
        .rstn(rstn),
        .d(host_bus_i),
        .q(bus_s)
    );

    assign {sel_s, rw_s, ds_n_s, wr_n_s, rd_n_s} = ctl_s;

    ////////////////////////////////////////////////////////////////////////////
    // Strobe decode

    logic rd_act;
    logic wr_act;

    always_comb
    begin
        if (VARIANT == vthp_pkg::VTHP_DATA_STROBE)
        begin
            rd_act = !ds_n_s && rw_s;
            wr_act = !ds_n_s && !rw_s;
        end
        else
        begin
            rd_act = !rd_n_s && wr_n_s;
            wr_act = !wr_n_s && rd_n_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access state machine

    vthp_pkg::vthp_state_t state_q;
    vthp_pkg::vthp_state_t state_d;
    logic [7:0] ptr_q;
    logic [7:0] wdata_q;
    logic wsel_q;
    logic done_q;
    logic commit;
    logic rd_start;
    logic data_commit;
    logic char_hit;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            vthp_pkg::VTHP_IDLE:
            begin
                if (rd_act)
                    state_d = vthp_pkg::VTHP_READ;
                else if (wr_act)
                    state_d = vthp_pkg::VTHP_WRITE;
            end
            vthp_pkg::VTHP_READ:
            begin
                if (!rd_act)
                    state_d = vthp_pkg::VTHP_IDLE;
            end
            vthp_pkg::VTHP_WRITE:
            begin
                if (!wr_act)
                    state_d = vthp_pkg::VTHP_IDLE;
            end
            default:
                state_d = vthp_pkg::VTHP_IDLE;
        endcase
    end

    assign commit = (state_q == vthp_pkg::VTHP_WRITE) && !wr_act;
    assign rd_start = (state_q == vthp_pkg::VTHP_IDLE) && rd_act;
    assign data_commit = commit && (wsel_q == `VTHP_SEL_DATA);
    assign char_hit = (ptr_q[`VTHP_PTR_MSB:`VTHP_PTR_LSB] == `VTHP_PTR_CHARACTER);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            state_q <= vthp_pkg::VTHP_IDLE;
        else
            state_q <= state_d;
    end

    // Latch byte and select while the write strobe is held
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wdata_q <= `VTHP_RST_BYTE;
            wsel_q <= `VTHP_SEL_DATA;
        end
        else if (wr_act)
        begin
            wdata_q <= bus_s;
            wsel_q <= sel_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pointer and data registers

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ptr_q <= `VTHP_RST_PTR;
        else if (commit && wsel_q == `VTHP_SEL_ADDR)
            ptr_q <= wdata_q;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            screen_top_address <= `VTHP_RST_BYTE;
            cursor_low <= `VTHP_RST_BYTE;
            cursor_high <= `VTHP_RST_BYTE;
            fill_end_address <= `VTHP_RST_BYTE;
            attribute_value <= `VTHP_RST_BYTE;
            mode_value <= `VTHP_RST_BYTE;
        end
        else if (data_commit)
        begin
            case (ptr_q[`VTHP_PTR_MSB:`VTHP_PTR_LSB])
                `VTHP_PTR_CHIP_RESET:
                begin
                    screen_top_address <= `VTHP_RST_BYTE;
                    cursor_low <= `VTHP_RST_BYTE;
                    cursor_high <= `VTHP_RST_BYTE;
                    fill_end_address <= `VTHP_RST_BYTE;
                    attribute_value <= `VTHP_RST_BYTE;
                    mode_value <= `VTHP_RST_BYTE;
                end
                `VTHP_PTR_SCREEN_TOP: screen_top_address <= wdata_q;
                `VTHP_PTR_CURSOR_LO: cursor_low <= wdata_q;
                `VTHP_PTR_CURSOR_HI: cursor_high <= wdata_q;
                `VTHP_PTR_FILL_END: fill_end_address <= wdata_q;
                `VTHP_PTR_ATTRIBUTE: attribute_value <= wdata_q;
                `VTHP_PTR_MODE: mode_value <= wdata_q;
                default: ;
            endcase
        end
    end

    // Character register: host write or display-memory load
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            char_value <= `VTHP_RST_BYTE;
        else if (data_commit && char_hit)
            char_value <= wdata_q;
        else if (char_load)
            char_value <= char_load_data;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control pulses and fill arming

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            chip_reset_pulse <= 1'b0;
            xfer_start <= 1'b0;
            fill_armed <= 1'b0;
        end
        else
        begin
            chip_reset_pulse <= data_commit
                && ptr_q[`VTHP_PTR_MSB:`VTHP_PTR_LSB] == `VTHP_PTR_CHIP_RESET;
            xfer_start <= (data_commit || (rd_start && sel_s == `VTHP_SEL_DATA)) && char_hit;
            if (data_commit && ptr_q[`VTHP_PTR_MSB:`VTHP_PTR_LSB] == `VTHP_PTR_FILL_END)
                fill_armed <= 1'b1;
            else if ((data_commit && char_hit)
                || (data_commit
                    && ptr_q[`VTHP_PTR_MSB:`VTHP_PTR_LSB] == `VTHP_PTR_CHIP_RESET))
                fill_armed <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Done flag; a completion in the clearing cycle wins

    logic char_access;
    assign char_access = char_hit && (data_commit || (rd_start && sel_s == `VTHP_SEL_DATA));

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            done_q <= `VTHP_RST_DONE;
        else if (xfer_done)
            done_q <= 1'b1;
        else if (char_access)
            done_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    logic [7:0] rd_mux;

    always_comb
    begin
        rd_mux = 8'h00;
        if (sel_s == `VTHP_SEL_ADDR)
            rd_mux[`VTHP_STAT_DONE_BIT] = done_q;
        else
        begin
            case (ptr_q[`VTHP_PTR_MSB:`VTHP_PTR_LSB])
                `VTHP_PTR_SCREEN_TOP: rd_mux = screen_top_address;
                `VTHP_PTR_CURSOR_LO: rd_mux = cursor_low;
                `VTHP_PTR_CURSOR_HI: rd_mux = cursor_high;
                `VTHP_PTR_FILL_END: rd_mux = fill_end_address;
                `VTHP_PTR_ATTRIBUTE: rd_mux = attribute_value;
                `VTHP_PTR_CHARACTER: rd_mux = char_value;
                `VTHP_PTR_MODE: rd_mux = mode_value;
                default: rd_mux = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            host_bus_oe <= 1'b0;
            host_bus_o <= 8'h00;
        end
        else
        begin
            host_bus_oe <= rd_act;
            host_bus_o <= rd_act ? rd_mux : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_oe_only_reading;
        @(posedge clk) disable iff (!rstn)
        host_bus_oe |-> $past(rd_act) && !$past(wr_act);
    endproperty
    a_oe_only_reading: assert property (p_oe_only_reading)
        else $error("bus driven outside a read");

    property p_no_oe_on_write;
        @(posedge clk) disable iff (!rstn)
        (state_q == vthp_pkg::VTHP_WRITE) |=> !host_bus_oe;
    endproperty
    a_no_oe_on_write: assert property (p_no_oe_on_write)
        else $error("bus driven during a write");

    property p_ptr_load;
        @(posedge clk) disable iff (!rstn)
        (commit && wsel_q == `VTHP_SEL_ADDR) |=> ptr_q == $past(wdata_q);
    endproperty
    a_ptr_load: assert property (p_ptr_load)
        else $error("pointer not loaded");

    property p_data_store;
        @(posedge clk) disable iff (!rstn)
        (data_commit && ptr_q[3:0] == `VTHP_PTR_CURSOR_LO) |=> cursor_low == $past(wdata_q);
    endproperty
    a_data_store: assert property (p_data_store)
        else $error("data register not stored");

    property p_commit_on_release;
        @(posedge clk) disable iff (!rstn)
        $changed(ptr_q) |-> $past(state_q) == vthp_pkg::VTHP_WRITE && !$past(wr_act);
    endproperty
    a_commit_on_release: assert property (p_commit_on_release)
        else $error("pointer changed without strobe release");

    property p_done_clear;
        @(posedge clk) disable iff (!rstn)
        (char_access && !xfer_done) |=> !done_q;
    endproperty
    a_done_clear: assert property (p_done_clear)
        else $error("done not cleared on character access");

    property p_done_set;
        @(posedge clk) disable iff (!rstn)
        xfer_done |=> done_q ##1 (done_q || $past(char_access));
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("done not set on completion");

    property p_status_read;
        @(posedge clk) disable iff (!rstn)
        (rd_act && sel_s == `VTHP_SEL_ADDR) |=> host_bus_o == {$past(done_q), 7'h00};
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read wrong");

    property p_chip_reset;
        @(posedge clk) disable iff (!rstn)
        chip_reset_pulse |-> mode_value == 8'h00 && screen_top_address == 8'h00 && !fill_armed;
    endproperty
    a_chip_reset: assert property (p_chip_reset)
        else $error("chip reset left state");

    property p_exclusive;
        @(posedge clk) disable iff (!rstn)
        !(rd_act && wr_act);
    endproperty
    a_exclusive: assert property (p_exclusive)
        else $error("read and write both active");

    c_read: cover property (@(posedge clk) disable iff (!rstn) rd_start ##1 host_bus_oe);
    c_write: cover property (@(posedge clk) disable iff (!rstn) data_commit && char_hit);
    c_fill: cover property (@(posedge clk) disable iff (!rstn)
        fill_armed && data_commit && char_hit);

endmodule // vthp_top

`default_nettype wire

// *** hw/vthp_regs.svh ***
`ifndef VTHP_REGS_SVH
`define VTHP_REGS_SVH

// Pointer codes of the indirectly addressed registers
`define VTHP_PTR_CHIP_RESET 4'h6
`define VTHP_PTR_SCREEN_TOP 4'h8
`define VTHP_PTR_CURSOR_LO 4'h9
`define VTHP_PTR_CURSOR_HI 4'ha
`define VTHP_PTR_FILL_END 4'hb
`define VTHP_PTR_ATTRIBUTE 4'hc
`define VTHP_PTR_CHARACTER 4'hd
`define VTHP_PTR_MODE 4'he

// Field positions
`define VTHP_PTR_MSB 3
`define VTHP_PTR_LSB 0
`define VTHP_STAT_DONE_BIT 7

// Register-select levels
`define VTHP_SEL_DATA 1'h0
`define VTHP_SEL_ADDR 1'h1

// Reset values
`define VTHP_RST_BYTE 8'h00
`define VTHP_RST_PTR 8'h00
`define VTHP_RST_DONE 1'h1

// Synchroniser depth from pin to stable level
`define VTHP_SYNC_STAGES 3

`endif

// *** hw/vthp_pkg.sv ***
package vthp_pkg;

    // Gray path: idle -> read -> idle, idle -> write -> idle
    typedef enum logic [1:0] {
        VTHP_IDLE  = 2'b00,
        VTHP_READ  = 2'b01,
        VTHP_WRITE = 2'b10
    } vthp_state_t;

    typedef enum logic {
        VTHP_SEPARATE_STROBES = 1'b0,
        VTHP_DATA_STROBE      = 1'b1
    } vthp_variant_t;

endpackage

// *** hw/vthp_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

// Three stages and an output flop per bit; output moves once stages two and three agree
module vthp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic o_q;
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    s1_q <= RST[i];
                    s2_q <= RST[i];
                    s3_q <= RST[i];
                    o_q <= RST[i];
                end
                else
                begin
                    s1_q <= d[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q)
                    begin
                        o_q <= s3_q;
                    end
                end
            end
            assign q[i] = o_q;
        end
    endgenerate

endmodule // vthp_sync

`default_nettype wire

// *** testbench/vthp_cpu_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// Processor side of the port, either strobe variant
module vthp_cpu_model #(
    parameter bit DS = 1'b0
) (
    input wire logic clk,
    input wire logic [7:0] dev_bus_o,
    input wire logic dev_bus_oe,
    output logic rd_n,
    output logic wr_n,
    output logic ds_n,
    output logic rw,
    output logic sel,
    output logic [7:0] bus_i
);
    logic [7:0] drv;
    logic drv_en;

    initial
    begin
        rd_n = 1'b1;
        wr_n = 1'b1;
        ds_n = 1'b1;
        rw = 1'b1;
        sel = 1'b0;
        drv = 8'h00;
        drv_en = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Wire level; a released bus shows the inverse of the last byte
    always_comb
    begin
        if (dev_bus_oe)
            bus_i = dev_bus_o;
        else if (drv_en)
            bus_i = drv;
        else
            bus_i = ~drv;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Strobes low with optional both-low abuse, data held past release
    task automatic access_wr(input logic s, input logic [7:0] b, input logic both);
        @(negedge clk);
        sel = s;
        drv = b;
        drv_en = 1'b1;
        if (DS)
        begin
            rw = 1'b0;
            ds_n = 1'b0;
        end
        else
        begin
            wr_n = 1'b0;
            rd_n = ~both;
        end
        repeat (6) @(negedge clk);
        wr_n = 1'b1;
        rd_n = 1'b1;
        ds_n = 1'b1;
        repeat (6) @(negedge clk);
        drv_en = 1'b0;
    endtask

    task automatic wr(input logic s, input logic [7:0] b);
        access_wr(s, b, 1'b0);
    endtask

    task automatic rd(input logic s, output logic [7:0] b, output logic ok);
        int n;
        @(negedge clk);
        sel = s;
        if (DS)
        begin
            rw = 1'b1;
            ds_n = 1'b0;
        end
        else
            rd_n = 1'b0;
        n = 0;
        while (dev_bus_oe !== 1'b1 && n < 12)
        begin
            @(negedge clk);
            n++;
        end
        ok = dev_bus_oe;
        b = bus_i;
        rd_n = 1'b1;
        ds_n = 1'b1;
        n = 0;
        while (dev_bus_oe !== 1'b0 && n < 12)
        begin
            @(negedge clk);
            n++;
        end
        repeat (4) @(negedge clk);
    endtask
endmodule // vthp_cpu_model

`default_nettype wire

// *** testbench/tb_video_ctrl_host_register_port.sv ***
`include "vthp_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module tb_video_ctrl_host_register_port;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic xfer_done = 1'b0;
    logic char_load = 1'b0;
    logic [7:0] char_load_data = 8'h00;
    logic rd_n, wr_n, sel, oe, armed, start, crst;
    logic [7:0] bus_i, bus_o, top, clo, chi, fend, attr, mode, chv;
    logic ds_n_ds, rw_ds, sel_ds, oe_ds;
    logic [7:0] bus_i_ds, bus_o_ds, chi_ds;
    int failures = 0;
    int compares = 0;
    int starts = 0;
    int resets = 0;
    logic [3:0] codes [6] = '{`VTHP_PTR_SCREEN_TOP, `VTHP_PTR_CURSOR_LO, `VTHP_PTR_CURSOR_HI,
        `VTHP_PTR_FILL_END, `VTHP_PTR_ATTRIBUTE, `VTHP_PTR_MODE};

    always #10 clk = ~clk;

    vthp_cpu_model cpu (.clk(clk), .dev_bus_o(bus_o), .dev_bus_oe(oe), .rd_n(rd_n),
        .wr_n(wr_n), .ds_n(), .rw(), .sel(sel), .bus_i(bus_i));

    vthp_cpu_model #(.DS(1'b1)) cpu_ds (.clk(clk), .dev_bus_o(bus_o_ds), .dev_bus_oe(oe_ds),
        .rd_n(), .wr_n(), .ds_n(ds_n_ds), .rw(rw_ds), .sel(sel_ds), .bus_i(bus_i_ds));

    vthp_top dut (.clk(clk), .rstn(rstn), .host_rd_n(rd_n), .host_wr_n(wr_n),
        .host_rw(1'b1), .host_data_strobe_n(1'b1), .host_sel(sel), .host_bus_i(bus_i),
        .host_bus_o(bus_o), .host_bus_oe(oe), .xfer_done(xfer_done), .char_load(char_load),
        .char_load_data(char_load_data), .screen_top_address(top), .cursor_low(clo),
        .cursor_high(chi), .fill_end_address(fend), .attribute_value(attr),
        .mode_value(mode), .char_value(chv), .fill_armed(armed), .xfer_start(start),
        .chip_reset_pulse(crst));

    // Second copy in the data-strobe variant
    vthp_top #(.VARIANT(vthp_pkg::VTHP_DATA_STROBE)) dut_ds (.clk(clk), .rstn(rstn),
        .host_rd_n(1'b1), .host_wr_n(1'b1), .host_rw(rw_ds), .host_data_strobe_n(ds_n_ds),
        .host_sel(sel_ds), .host_bus_i(bus_i_ds), .host_bus_o(bus_o_ds), .host_bus_oe(oe_ds),
        .xfer_done(xfer_done), .char_load(char_load), .char_load_data(char_load_data),
        .screen_top_address(), .cursor_low(), .cursor_high(chi_ds), .fill_end_address(),
        .attribute_value(), .mode_value(), .char_value(), .fill_armed(), .xfer_start(),
        .chip_reset_pulse());

    always @(posedge clk)
    begin
        if (start === 1'b1)
            starts++;
        if (crst === 1'b1)
            resets++;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        if (failures == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    function automatic logic [7:0] reg_out(input logic [3:0] c);
        case (c)
            `VTHP_PTR_SCREEN_TOP: return top;
            `VTHP_PTR_CURSOR_LO: return clo;
            `VTHP_PTR_CURSOR_HI: return chi;
            `VTHP_PTR_FILL_END: return fend;
            `VTHP_PTR_ATTRIBUTE: return attr;
            default: return mode;
        endcase
    endfunction

    // Read through the bus and compare, including the drive enable
    task automatic rd_chk(input logic s, input logic [7:0] exp);
        logic [7:0] b;
        logic ok;
        cpu.rd(s, b, ok);
        chk({7'h0, ok}, 8'h01);
        chk(b, exp);
    endtask

    task automatic done_pulse();
        @(negedge clk);
        xfer_done = 1'b1;
        @(negedge clk);
        xfer_done = 1'b0;
        repeat (2) @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int i = 0; i < 6; i++)
            chk(reg_out(codes[i]), 8'h00);
        chk({7'h0, oe}, 8'h00);
        rd_chk(`VTHP_SEL_ADDR, 8'h80);
    endtask

    task automatic t_regs();
        for (int i = 0; i < 6; i++)
        begin
            cpu.wr(`VTHP_SEL_ADDR, {4'h0, codes[i]});
            cpu.wr(`VTHP_SEL_DATA, {codes[i], ~codes[i]});
            chk({7'h0, oe}, 8'h00);
            chk(reg_out(codes[i]), {codes[i], ~codes[i]});
            rd_chk(`VTHP_SEL_DATA, {codes[i], ~codes[i]});
        end
    endtask

    task automatic t_char();
        int s0;
        chk({7'h0, armed}, 8'h01);
        cpu.wr(`VTHP_SEL_ADDR, {4'h0, `VTHP_PTR_CHARACTER});
        s0 = starts;
        cpu.wr(`VTHP_SEL_DATA, 8'h41);
        chk(chv, 8'h41);
        chk({7'h0, armed}, 8'h00);
        chk(8'(starts - s0), 8'h01);
        rd_chk(`VTHP_SEL_ADDR, 8'h00);
        done_pulse();
        rd_chk(`VTHP_SEL_ADDR, 8'h80);
    endtask

    task automatic t_load();
        int s0;
        @(negedge clk);
        char_load_data = 8'h5a;
        char_load = 1'b1;
        @(negedge clk);
        char_load = 1'b0;
        s0 = starts;
        rd_chk(`VTHP_SEL_DATA, 8'h5a);
        chk(8'(starts - s0), 8'h01);
        rd_chk(`VTHP_SEL_ADDR, 8'h00);
        done_pulse();
    endtask

    // Both strobes low touch nothing; pointer keeps screen top
    task automatic t_both();
        cpu.wr(`VTHP_SEL_ADDR, {4'h0, `VTHP_PTR_SCREEN_TOP});
        cpu.access_wr(`VTHP_SEL_ADDR, 8'h0c, 1'b1);
        cpu.wr(`VTHP_SEL_DATA, 8'h3c);
        chk(top, 8'h3c);
        chk(attr, {`VTHP_PTR_ATTRIBUTE, ~`VTHP_PTR_ATTRIBUTE});
    endtask

    task automatic t_ptr_edges();
        cpu.wr(`VTHP_SEL_ADDR, 8'hf9);
        cpu.wr(`VTHP_SEL_DATA, 8'h12);
        chk(clo, 8'h12);
        cpu.wr(`VTHP_SEL_ADDR, 8'h03);
        cpu.wr(`VTHP_SEL_DATA, 8'h77);
        rd_chk(`VTHP_SEL_DATA, 8'h00);
        chk(clo, 8'h12);
    endtask

    task automatic t_chip_reset();
        int r0;
        cpu.wr(`VTHP_SEL_ADDR, {4'h0, `VTHP_PTR_FILL_END});
        cpu.wr(`VTHP_SEL_DATA, 8'h2d);
        chk({7'h0, armed}, 8'h01);
        r0 = resets;
        cpu.wr(`VTHP_SEL_ADDR, {4'h0, `VTHP_PTR_CHIP_RESET});
        cpu.wr(`VTHP_SEL_DATA, 8'h00);
        chk(8'(resets - r0), 8'h01);
        for (int i = 0; i < 6; i++)
            chk(reg_out(codes[i]), 8'h00);
        chk(chv, 8'h5a);
        chk({7'h0, armed}, 8'h00);
    endtask

    // Data-strobe copy: read/write select gives the direction
    task automatic t_data_strobe();
        logic [7:0] b;
        logic ok;
        cpu_ds.rd(`VTHP_SEL_ADDR, b, ok);
        chk({7'h0, ok}, 8'h01);
        chk(b, 8'h80);
        cpu_ds.wr(`VTHP_SEL_ADDR, {4'h0, `VTHP_PTR_CURSOR_HI});
        cpu_ds.wr(`VTHP_SEL_DATA, 8'h5c);
        chk({7'h0, oe_ds}, 8'h00);
        chk(chi_ds, 8'h5c);
        chk(chi, 8'h00);
        cpu_ds.rd(`VTHP_SEL_DATA, b, ok);
        chk({7'h0, ok}, 8'h01);
        chk(b, 8'h5c);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        t_reset();
        t_data_strobe();
        t_regs();
        t_char();
        t_load();
        t_both();
        t_ptr_edges();
        t_chip_reset();
        end_of_test();
    end

    initial
    begin
        #200000;
        failures++;
        end_of_test();
    end
endmodule // tb_video_ctrl_host_register_port

`default_nettype wire
